// File: shared/lsp_pkg.sv
package lsp_pkg;
	// ----------------------------------------------------------------
	// Register map (word index, byte address = 4 * index)
	// ----------------------------------------------------------------
	localparam logic [5:0] SEG_EN_BASE_IDX = 6'h00;  // Six segment enable regs
	localparam logic [5:0] PIX_BASE_IDX    = 6'h08;  // Twenty-four pixel regs
	localparam logic [5:0] CTRL_IDX        = 6'h20;  // Control register
	localparam logic [5:0] PRESC_IDX       = 6'h21;  // Phase/prescale register
	localparam logic [5:0] REG_CTRL_IDX    = 6'h22;  // Regulator control register
	localparam logic [5:0] OSC_CTRL_IDX    = 6'h23;  // Oscillator enables
	localparam int         NUM_SEG_REGS    = 6;
	localparam int         NUM_PIX_REGS    = 24;
	localparam int         PIX_PER_COM     = 6;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int CTRL_WRERR_BIT = 5;
	localparam int CTRL_CS_LSB    = 2;
	localparam int CTRL_MUX_LSB   = 0;
	localparam int PRESC_WRALW_BIT = 4;
	localparam int PRESC_LP_LSB   = 0;
	localparam int REG_CKSEL_LSB  = 0;
	localparam int REG_MODE13_BIT = 2;
	localparam int OSC_T1EN_BIT   = 0;
	localparam int OSC_RCEN_BIT   = 1;
	localparam int OSC_T1USE_BIT  = 2;

	// ----------------------------------------------------------------
	// Reset values and divider counts
	// ----------------------------------------------------------------
	localparam logic [7:0]  REG_RESET     = 8'h00;
	localparam logic [12:0] POST_DIV_SYS  = 13'h1fff;  // Divide-by-8192 minus one
	localparam logic [12:0] POST_DIV_SLOW = 13'h001f;  // Divide-by-32 minus one
	localparam logic [7:0]  PUMP_DIV_OSC  = 8'hff;     // Divide-by-256 minus one
	localparam logic [5:0]  SEG_SHARED_T1 = 6'h20;     // Segment lost to timer1 use

	typedef enum logic [1:0] {
		LSP_SRC_SYS = 2'b00,
		LSP_SRC_T1  = 2'b01,
		LSP_SRC_RC  = 2'b10
	} lsp_src_t;

	typedef enum logic [1:0] {
		LSP_MUX_STATIC = 2'b00,
		LSP_MUX_HALF   = 2'b01,
		LSP_MUX_THIRD  = 2'b10,
		LSP_MUX_QUART  = 2'b11
	} lsp_mux_t;

	typedef enum logic [1:0] {
		LSP_BIAS_STATIC = 2'b00,
		LSP_BIAS_HALF   = 2'b01,
		LSP_BIAS_THIRD  = 2'b10
	} lsp_bias_t;

	// Clock-source tick inputs
	typedef struct packed {
		logic sys_tick;   // Instruction clock tick
		logic t1_tick;    // Timer1 oscillator tick
		logic rc_tick;    // Internal RC tick
		logic osc_tick;   // 8 MHz internal oscillator tick
	} lsp_ticks_t;

	// Timing outputs towards the waveform generator
	typedef struct packed {
		logic      frame_tick;
		logic      phase_tick;
		logic [3:0] com_active;
		logic [1:0] com_index;
		logic      pump_tick;
		lsp_bias_t bias;
	} lsp_timing_t;
endpackage

// File: rtl/lsp_lcd_clkgen.sv
`timescale 1ns/1ns
// Operation
// [RULE1] Set enable bit gives pin to LCD
// [RULE2] Six enable registers, eight segments each
// [RULE3] Small variant drops segments 33 to 47
// [RULE4] Pixel bit one means dark segment
// [RULE5] Pixel registers grouped six per common
// [RULE6] Small variant ignores segment 40-47 pixels
// [RULE7] Small variant keeps only segment 32 bit
// [RULE8] Three sources, postscale to 1 kHz baseline
// [RULE9] Instruction clock always divides by 8192
// [RULE10] Slow sources divide by 32
// [RULE11] Frame prescaler divides 1 to 16
// [RULE12] Mux field sets commons ring counter
// [RULE13] Charge pump clock from three sources
// [RULE14] Selecting source never starts oscillator
// [RULE15] Pump selection never starts 8 MHz oscillator
// [RULE16] Software enables timer1 oscillator first
// [RULE17] Slow sources keep running in sleep
// [RULE18] Timer1 use removes segment 32
// [RULE19] Static, half and third bias types
// [RULE20] Source field 00 sys, 01 t1, 1x rc
// [RULE21] Mux field static, half, third, quarter
// [RULE22] Forbidden pixel write sets sticky error
module lsp_lcd_clkgen #(
	parameter bit SMALL_VARIANT = 1'b0
) (
	input  wire logic                 I_CLOCK,
	input  wire logic                 I_RST,
	input  wire logic [31:0]          I_WB_ADR,
	input  wire logic [31:0]          I_WB_DAT,
	input  wire logic [3:0]           I_WB_SEL,
	input  wire logic                 I_WB_WE,
	input  wire logic                 I_WB_CYC,
	input  wire logic                 I_WB_STB,
	input  wire logic                 I_SLEEP,
	input  wire logic                 I_OSC_IS_SYSCLK,
	input  wire lsp_pkg::lsp_ticks_t  I_TICKS,
	output logic [31:0]               O_WB_DAT,
	output logic                      O_WB_ACK,
	output logic [47:0]               O_SEG_LCD_MODE,
	output logic [47:0]               O_SEG_DATA,
	output logic                      O_T1_OSC_RUN,
	output logic                      O_RC_OSC_RUN,
	output logic                      O_WRITE_ALLOWED,
	output lsp_pkg::lsp_timing_t      O_TIMING
);
	import lsp_pkg::*;

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [NUM_SEG_REGS-1:0][7:0] seg_en;
		logic [NUM_PIX_REGS-1:0][7:0] pix;
		logic        pixel_write_error_flag;
		logic [1:0]  cs;
		lsp_mux_t    mux;
		logic        bias_half;
		logic [3:0]  lp;
		logic [1:0]  cksel;
		logic        mode13;
		logic [2:0]  osc_ctl;
		logic        ack;
		logic [31:0] rdat;
		logic [12:0] post_cnt;
		logic [3:0]  pre_cnt;
		logic [1:0]  com_idx;
		logic [7:0]  pump_cnt;
		logic        frame_tick;
		logic        phase_tick;
		logic        pump_tick;
		logic [47:0] seg_data;
	} lsp_state_t;

	lsp_state_t s_r;
	lsp_state_t s_nxt;

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	// Mask of implemented bits for a segment-numbered byte group
	function automatic logic [7:0] grp_mask(input int grp);
		logic [7:0] m;
		m = 8'hff;
		if (SMALL_VARIANT && grp == 4)
			m = 8'h01;                                    // [RULE3] [RULE7]
		else if (SMALL_VARIANT && grp == 5)
			m = 8'h00;                                    // [RULE3] [RULE6]
		return m;
	endfunction

	// Last common index for the selected multiplex
	function automatic logic [1:0] last_com(input lsp_mux_t mx);
		return 2'(mx);                                    // [RULE21]
	endfunction

	logic        t1_in_use;
	logic        src_tick;
	logic        pump_src;
	logic [5:0]  idx;
	logic        bus_req;
	logic        wr;
	logic [3:0]  com_mask;

	// ----------------------------------------------------------------
	// Combinational source selection
	// ----------------------------------------------------------------
	always_comb begin
		idx = I_WB_ADR[7:2];
		bus_req = I_WB_CYC && I_WB_STB && !s_r.ack;
		wr = bus_req && I_WB_WE && I_WB_SEL[0];
		t1_in_use = s_r.osc_ctl[OSC_T1EN_BIT] || s_r.osc_ctl[OSC_T1USE_BIT]
			|| s_r.cksel == 2'b01;
		// Ticks only count when that oscillator really runs; selection alone does not
		// start it, and the instruction clock stops in sleep
		if (s_r.cs[1])                                    // [RULE20]
			src_tick = I_TICKS.rc_tick && s_r.osc_ctl[OSC_RCEN_BIT]; // [RULE14] [RULE17]
		else if (s_r.cs[0])
			src_tick = I_TICKS.t1_tick && s_r.osc_ctl[OSC_T1EN_BIT]; // [RULE14] [RULE16]
		else
			src_tick = I_TICKS.sys_tick && !I_SLEEP;      // [RULE17]
		unique case (s_r.cksel)                           // [RULE13]
			2'b00: pump_src = 1'b0;
			2'b01: pump_src = I_TICKS.t1_tick && s_r.osc_ctl[OSC_T1EN_BIT];
			2'b10: pump_src = I_TICKS.osc_tick && I_OSC_IS_SYSCLK; // [RULE15]
			2'b11: pump_src = I_TICKS.rc_tick && s_r.osc_ctl[OSC_RCEN_BIT];
		endcase
		// Ring counter: one common active, wraps at mux limit
		com_mask = 4'b0001 << s_r.com_idx;                // [RULE12]
	end

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		s_nxt = s_r;
		s_nxt.ack = bus_req;
		s_nxt.frame_tick = 1'b0;
		s_nxt.phase_tick = 1'b0;
		s_nxt.pump_tick = 1'b0;

		// Register writes
		if (wr) begin
			for (int k = 0; k < NUM_SEG_REGS; k++) begin
				if (idx == SEG_EN_BASE_IDX + 6'(k))
					s_nxt.seg_en[k] = I_WB_DAT[7:0] & grp_mask(k); // [RULE2] [RULE3]
			end
			for (int k = 0; k < NUM_PIX_REGS; k++) begin
				if (idx == PIX_BASE_IDX + 6'(k)) begin
					if (O_WRITE_ALLOWED)
						s_nxt.pix[k] = I_WB_DAT[7:0] & grp_mask(k % PIX_PER_COM); // [RULE5]
				end
			end
			if (idx == CTRL_IDX) begin
				s_nxt.cs = I_WB_DAT[CTRL_CS_LSB +: 2];
				s_nxt.mux = lsp_mux_t'(I_WB_DAT[CTRL_MUX_LSB +: 2]);
				// Write one leaves the flag, zero clears it
				if (!I_WB_DAT[CTRL_WRERR_BIT])
					s_nxt.pixel_write_error_flag = 1'b0;
			end
			if (idx == PRESC_IDX) begin
				s_nxt.lp = I_WB_DAT[PRESC_LP_LSB +: 4];
				s_nxt.bias_half = I_WB_DAT[6];
			end
			if (idx == REG_CTRL_IDX) begin
				s_nxt.cksel = I_WB_DAT[REG_CKSEL_LSB +: 2];
				s_nxt.mode13 = I_WB_DAT[REG_MODE13_BIT];
			end
			if (idx == OSC_CTRL_IDX)
				s_nxt.osc_ctl = I_WB_DAT[2:0];
		end
		// Error set after clear so a refused write is never lost
		if (wr && !O_WRITE_ALLOWED && idx >= PIX_BASE_IDX
				&& idx < PIX_BASE_IDX + 6'(NUM_PIX_REGS))
			s_nxt.pixel_write_error_flag = 1'b1;                            // [RULE22]

		// Read mux
		s_nxt.rdat = 32'h0;
		for (int k = 0; k < NUM_SEG_REGS; k++)
			if (idx == SEG_EN_BASE_IDX + 6'(k))
				s_nxt.rdat[7:0] = s_r.seg_en[k];
		for (int k = 0; k < NUM_PIX_REGS; k++)
			if (idx == PIX_BASE_IDX + 6'(k))
				s_nxt.rdat[7:0] = s_r.pix[k];
		if (idx == CTRL_IDX)
			s_nxt.rdat[7:0] = {2'b00, s_r.pixel_write_error_flag, 1'b0, s_r.cs, 2'(s_r.mux)};
		if (idx == PRESC_IDX)
			s_nxt.rdat[7:0] = {1'b0, s_r.bias_half, 1'b0, O_WRITE_ALLOWED, s_r.lp};
		if (idx == REG_CTRL_IDX)
			s_nxt.rdat[7:0] = {5'h00, s_r.mode13, s_r.cksel};
		if (idx == OSC_CTRL_IDX)
			s_nxt.rdat[7:0] = {5'h00, s_r.osc_ctl};

		// Postscaler to 1 kHz, then frame prescaler, then ring counter
		if (src_tick) begin
			// Sys clock always 8192; slow sources always 32
			if (s_r.post_cnt >= (s_r.cs == 2'b00 ? POST_DIV_SYS : POST_DIV_SLOW)) begin
				s_nxt.post_cnt = 13'h0;                   // [RULE8] [RULE9] [RULE10]
				s_nxt.phase_tick = 1'b1;
				if (s_r.pre_cnt >= s_r.lp) begin
					s_nxt.pre_cnt = 4'h0;                 // [RULE11]
					s_nxt.frame_tick = 1'b1;
					if (s_r.com_idx >= last_com(s_r.mux))
						s_nxt.com_idx = 2'b00;            // [RULE12]
					else
						s_nxt.com_idx = s_r.com_idx + 2'b01;
				end else begin
					s_nxt.pre_cnt = s_r.pre_cnt + 4'h1;
				end
			end else begin
				s_nxt.post_cnt = s_r.post_cnt + 13'h1;
			end
		end

		// Charge pump: 8 MHz branch divided by 256, timer1 and RC direct, field 00 gives no pump clock
		if (pump_src) begin
			if (s_r.cksel != 2'b10 || s_r.pump_cnt == PUMP_DIV_OSC) begin
				s_nxt.pump_cnt = 8'h00;                   // [RULE13]
				s_nxt.pump_tick = 1'b1;
			end else begin
				s_nxt.pump_cnt = s_r.pump_cnt + 8'h01;
			end
		end

		// Displayed segment values for the active common
		for (int g = 0; g < NUM_SEG_REGS; g++)
			s_nxt.seg_data[g*8 +: 8] = s_r.pix[32'(s_r.com_idx) * PIX_PER_COM + g]; // [RULE4]
		if (t1_in_use)
			s_nxt.seg_data[SEG_SHARED_T1] = 1'b0;         // [RULE18]
	end

	// ----------------------------------------------------------------
	// Register update
	// ----------------------------------------------------------------
	always_ff @(posedge I_CLOCK) begin
		if (I_RST)
			s_r <= '0;
		else
			s_r <= s_nxt;
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	// Writes allowed outside the frame-boundary update cycle
	assign O_WRITE_ALLOWED = !s_r.frame_tick;
	assign O_WB_ACK = s_r.ack;
	assign O_WB_DAT = s_r.rdat;
	assign O_T1_OSC_RUN = s_r.osc_ctl[OSC_T1EN_BIT];     // [RULE14]
	assign O_RC_OSC_RUN = s_r.osc_ctl[OSC_RCEN_BIT];

	// Pin ownership; segment 32 goes back to I/O while timer1 is in use
	always_comb begin
		O_SEG_LCD_MODE = s_r.seg_en;                      // [RULE1]
		if (t1_in_use)
			O_SEG_LCD_MODE[SEG_SHARED_T1] = 1'b0;         // [RULE18]
		O_SEG_DATA = s_r.seg_data;
		O_TIMING.frame_tick = s_r.frame_tick;
		O_TIMING.phase_tick = s_r.phase_tick;
		O_TIMING.com_active = com_mask;
		O_TIMING.com_index = s_r.com_idx;
		O_TIMING.pump_tick = s_r.pump_tick;
		// Static mux is static bias; quarter forces third
		if (s_r.mux == LSP_MUX_STATIC)
			O_TIMING.bias = LSP_BIAS_STATIC;              // [RULE19]
		else if (s_r.bias_half && s_r.mux != LSP_MUX_QUART)
			O_TIMING.bias = LSP_BIAS_HALF;
		else
			O_TIMING.bias = LSP_BIAS_THIRD;
	end
endmodule

// File: verif/lsp_panel_model.sv
`timescale 1ns/1ns
// ------------
// Glass panel
// ------------
module lsp_panel_model (
	input  wire logic [47:0] i_seg_data,
	input  wire logic [47:0] i_lcd_mode,
	output logic      [47:0] o_dark
);
	// A pixel darkens only where the pin is owned by the LCD driver
	assign o_dark = i_seg_data & i_lcd_mode;
endmodule

// File: verif/lsp_lcd_clkgen_sva.sv
`timescale 1ns/1ns
// ------------
// Port checks
// ------------
module lsp_lcd_sva (
	input wire logic                 I_CLOCK,
	input wire logic                 I_RST,
	input wire logic                 I_WB_CYC,
	input wire logic                 I_WB_STB,
	input wire logic                 I_WB_WE,
	input wire logic                 O_WB_ACK,
	input wire logic [31:0]          O_WB_DAT,
	input wire logic [47:0]          O_SEG_LCD_MODE,
	input wire logic                 O_T1_OSC_RUN,
	input wire logic                 O_WRITE_ALLOWED,
	input wire lsp_pkg::lsp_timing_t O_TIMING
);
	import lsp_pkg::*;
	default clocking @(posedge I_CLOCK); endclocking
	default disable iff (I_RST);
	// Bus request and its one-cycle answer
	sequence s_req;
		I_WB_CYC && I_WB_STB && !O_WB_ACK;
	endsequence
	sequence s_ack;
		O_WB_ACK ##1 !O_WB_ACK;
	endsequence
	a_ack_next: assert property (s_req |=> s_ack)
		else $error("ack not a one-cycle answer");
	a_ack_cause: assert property (O_WB_ACK |-> $past(I_WB_CYC && I_WB_STB))
		else $error("ack without request");
	a_rdat_narrow: assert property (O_WB_ACK |-> O_WB_DAT[31:8] == 24'h0)
		else $error("read data upper bits set");
	a_seg32_lost: assert property (O_T1_OSC_RUN |-> !O_SEG_LCD_MODE[32])
		else $error("segment 32 kept with timer1 in use");
	a_write_block: assert property (O_TIMING.frame_tick |-> !O_WRITE_ALLOWED)
		else $error("pixel write allowed at frame edge");
	a_com_onehot: assert property ($onehot(O_TIMING.com_active))
		else $error("commons not one-hot");
	a_bias_legal: assert property (O_TIMING.bias != 2'b11)
		else $error("illegal bias type");
	a_osc_by_write: assert property ($changed(O_T1_OSC_RUN) |-> $past(I_WB_CYC && I_WB_WE))
		else $error("oscillator enable moved without write");
	a_frame_pulse: assert property (O_TIMING.frame_tick |=> !O_TIMING.frame_tick)
		else $error("frame tick longer than a cycle");
endmodule

bind lsp_lcd_clkgen lsp_lcd_sva u_lsp_lcd_sva (.I_CLOCK(I_CLOCK), .I_RST(I_RST),
	.I_WB_CYC(I_WB_CYC), .I_WB_STB(I_WB_STB), .I_WB_WE(I_WB_WE), .O_WB_ACK(O_WB_ACK),
	.O_WB_DAT(O_WB_DAT), .O_SEG_LCD_MODE(O_SEG_LCD_MODE), .O_T1_OSC_RUN(O_T1_OSC_RUN),
	.O_WRITE_ALLOWED(O_WRITE_ALLOWED), .O_TIMING(O_TIMING));

// File: verif/testbench.sv
`timescale 1ns/1ns
// ------------
// Bench top
// ------------
module testbench;
	import lsp_pkg::*;
	logic        clk, rst, we, cyc, stb, slp, oss, ack, t1r, rcr, wal;
	logic [31:0] adr, dat, rdat, lf;
	logic [3:0]  sel;
	lsp_ticks_t  tk;
	lsp_timing_t tim;
	logic [47:0] mode, sdat, dark, em, ed;
	logic [7:0]  q, v, img [0:23];
	int          failures, checks_done, pt, p0, p3, ps, pz, c;

	lsp_lcd_clkgen u_lsp_lcd_clkgen (.I_CLOCK(clk), .I_RST(rst), .I_WB_ADR(adr),
		.I_WB_DAT(dat), .I_WB_SEL(sel), .I_WB_WE(we), .I_WB_CYC(cyc), .I_WB_STB(stb),
		.I_SLEEP(slp), .I_OSC_IS_SYSCLK(oss), .I_TICKS(tk), .O_WB_DAT(rdat), .O_WB_ACK(ack),
		.O_SEG_LCD_MODE(mode), .O_SEG_DATA(sdat), .O_T1_OSC_RUN(t1r), .O_RC_OSC_RUN(rcr),
		.O_WRITE_ALLOWED(wal), .O_TIMING(tim));
	lsp_panel_model u_lsp_panel_model (.i_seg_data(sdat), .i_lcd_mode(mode), .o_dark(dark));

	// 250 MHz clock
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	function automatic logic [31:0] nx(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	task automatic chk(input string nm, input logic [47:0] e, input logic [47:0] s);
		checks_done++;
		if (s !== e) begin
			failures++;
			$display("unexpected %s expected %h seen %h", nm, e, s);
		end
	endtask

	// Classic single cycle; waits for ack, never assumes its delay
	task automatic wb(input logic w, input logic [5:0] a, input logic [7:0] d,
		output logic [7:0] r);
		int n;
		n = 0;
		@(posedge clk);
		{cyc, stb, we, adr, dat} <= {2'b11, w, 24'h0, a, 2'b00, 24'h0, d};
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'b1 && n < 50);
		r = rdat[7:0];
		{cyc, stb} <= 2'b00;
		if (n >= 50) failures++;
	endtask

	// Cycles between two frame ticks; the first tick resyncs after a change
	task automatic per(output int p);
		int n;
		n = 0;
		p = 0;
		@(posedge clk);
		while (tim.frame_tick !== 1'b1 && n < 40000) begin
			@(posedge clk);
			n++;
		end
		do begin
			@(posedge clk);
			p++;
		end while (tim.frame_tick !== 1'b1 && p < 40000);
	endtask

	task final_report();
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask

	// Watchdog, well beyond the slow system-clock frame measurement
	initial begin
		#200000;
		failures++;
		final_report();
	end

	// Main sequence
	initial begin
		{rst, we, cyc, stb, slp, oss} = 6'b100000;
		{adr, dat, sel, tk, lf} = {64'h0, 4'hf, 4'h0, 32'ha4f6};
		{failures, checks_done, em, ed} = '0;
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		for (int i = 0; i < 32; i++) begin
			wb(1'b0, i[5:0], 8'h00, q);
			chk("reset value", 48'h0, 48'(q));
		end
		wb(1'b1, 6'h3f, 8'hff, q);
		wb(1'b0, 6'h3f, 8'h00, q);
		chk("unmapped", 48'h0, 48'(q));
		$display("test reset done");
		for (int k = 0; k < NUM_SEG_REGS; k++) begin
			lf = nx(lf);
			v = (k == 0) ? 8'hff : lf[7:0];
			em[8*k +: 8] = v;
			wb(1'b1, SEG_EN_BASE_IDX + 6'(k), v, q);
			wb(1'b0, SEG_EN_BASE_IDX + 6'(k), 8'h00, q);
			chk("seg enable", 48'(v), 48'(q));
			chk("pin mode", 48'(v), 48'(mode[8*k +: 8]));
		end
		for (int i = 0; i < NUM_PIX_REGS; i++) begin
			lf = nx(lf);
			img[i] = lf[7:0];
			if (i < PIX_PER_COM) ed[8*i +: 8] = img[i];
			wb(1'b1, PIX_BASE_IDX + 6'(i), img[i], q);
			wb(1'b0, PIX_BASE_IDX + 6'(i), 8'h00, q);
			chk("pixel", 48'(img[i]), 48'(q));
		end
		chk("com0 data", ed, sdat);
		chk("panel dark", ed & em, dark);
		$display("test registers done");
		wb(1'b1, CTRL_IDX, 8'h04, q);
		chk("t1 idle", 48'h0, 48'(t1r));
		wb(1'b1, OSC_CTRL_IDX, 8'h01, q);
		chk("t1 run", 48'h1, 48'(t1r));
		chk("seg32 lost", 48'h0, 48'(mode[32]));
		tk <= '1;
		per(pt);
		wb(1'b1, CTRL_IDX, 8'h08, q);
		chk("rc idle", 48'h0, 48'(rcr));
		wb(1'b1, OSC_CTRL_IDX, 8'h03, q);
		chk("rc run", 48'h1, 48'(rcr));
		per(p0);
		chk("t1 vs rc", 48'(pt), 48'(p0));
		chk("postscale", 48'h0, 48'(p0 % 32));
		wb(1'b1, PRESC_IDX, 8'h03, q);
		per(p3);
		chk("prescale", 48'(4 * p0), 48'(p3));
		slp <= 1'b1;
		per(ps);
		chk("sleep rc", 48'(p3), 48'(ps));
		slp <= 1'b0;
		wb(1'b1, PRESC_IDX, 8'h00, q);
		wb(1'b1, CTRL_IDX, 8'h00, q);
		per(pz);
		chk("sys ratio", 48'(256 * p0), 48'(pz));
		$display("test clocks done");
		wb(1'b1, REG_CTRL_IDX, 8'h02, q);
		for (int r = 0; r < 2; r++) begin
			oss <= r[0];
			c = 0;
			repeat (600) begin
				@(posedge clk);
				if (tim.pump_tick === 1'b1) c++;
			end
			chk("pump ticks", 48'(r), 48'(c > 0));
		end
		$display("test pump done");
		final_report();
	end
endmodule
